// file: common/rspwm_pkg.sv
// constants, register map and pin carrier for the reset-synchronous pwm timer
// Operation
// - each counter: 16-bit readable writable up-counter
// - period counter clears on period compare match
// - period sync pin toggles on toggle compare
// - three pwm pins, each with inverse pin
// - second counter free-running, toggles on compare
// - first irq on period counter toggle match
// - second irq on free counter toggle match
// - start bits run or stop each counter
// - mode bits 7..4 select buffer operation
// - mode bit 0 clear: counters independent
// - level select one: start low, active high
// - combination field 01 selects pwm mode
// - output enable bit zero drives its pin
// - initial level register sets pre-match pin levels
// - general registers 16-bit, compared every count
// - counters count rising edges of system clock
// - control bits 7..5: 001 period clear, 000 none
// - edge 00 rising, prescale 000 system clock
package rspwm_pkg;

    localparam int RSPWM_ADDR_W = 26;

    // register indices; byte address is four times the index
    localparam logic [23:0] IDX_START = 24'hff_f720;
    localparam logic [23:0] IDX_MODE = 24'hff_f721;
    localparam logic [23:0] IDX_FUNC = 24'hff_f723;
    localparam logic [23:0] IDX_OE = 24'hff_f724;
    localparam logic [23:0] IDX_OCR = 24'hff_f725;
    localparam logic [23:0] IDX_TCR [2] = '{24'hff_f700, 24'hff_f710};
    localparam logic [23:0] IDX_CNT [2] = '{24'hff_f706, 24'hff_f716};
    // general registers per channel, order a, b, c, d
    localparam logic [23:0] IDX_GR [2][4] = '{'{24'hff_f708, 24'hff_f70a, 24'hff_f70c, 24'hff_f70e},
                                              '{24'hff_f718, 24'hff_f71a, 24'hff_f71c, 24'hff_f71e}};

    localparam logic [1:0] START_RST = 2'h0;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [7:0] OE_RST = 8'hff;
    localparam logic [7:0] OCR_RST = 8'h00;
    localparam logic [7:0] TCR_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST = 16'hffff;

    localparam int MODE_SYNC = 0;
    localparam int MODE_BUF_LSB = 4;
    localparam int FUNC_LVL_SEL0 = 2;
    localparam int FUNC_LVL_SEL1 = 3;
    localparam logic [1:0] CMD_RSPWM = 2'h1;
    localparam logic [2:0] CLR_PERIOD = 3'h1;
    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [2:0] PSC_SYS = 3'h0;

    // pin bit positions inside the pin carrier
    localparam int PIN_B0 = 1;
    localparam int PIN_D0 = 3;
    localparam int PIN_A1 = 4;
    localparam int PIN_B1 = 5;
    localparam int PIN_C1 = 6;
    localparam int PIN_D1 = 7;

    typedef struct packed {
        logic pwm_three_inverse_pin;
        logic pwm_two_inverse_pin;
        logic pwm_three_pin;
        logic pwm_two_pin;
        logic pwm_one_inverse_pin;
        logic period_sync_pin;
        logic pwm_one_pin;
        logic first_channel_a_pin;
    } rspwm_pins_t;

endpackage

// file: design/rspwm_timer.sv
// two-channel 16-bit timer with reset-synchronous pwm outputs and apb registers
`timescale 1ns/1ps
`default_nettype none
module rspwm_timer import rspwm_pkg::*; #(
    parameter int ADDR_W = RSPWM_ADDR_W
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output rspwm_pins_t TIMER_PIN_O,
    output rspwm_pins_t TIMER_PIN_OE,
    output logic SECOND_TOGGLE_O,
    output logic FIRST_CHANNEL_IRQ,
    output logic SECOND_CHANNEL_IRQ
);

    logic [1:0] start_r;
    logic [7:0] mode_r;
    logic [7:0] func_r;
    logic [7:0] oe_r;
    logic [7:0] ocr_r;
    logic [7:0] tcr_r [2];
    logic [15:0] cnt_r [2];
    logic [15:0] gr_r [2][4];
    logic [7:0] lvl_r;
    logic [2:0] act_r;
    logic started_r;
    logic [7:0] pin_r;
    logic irq0_r;
    logic irq1_r;
    logic [31:0] prdata_r;
    logic hit_r;

    logic [23:0] idx;
    logic wr_acc;
    logic ocr_wr;
    logic [31:0] rd_val;
    logic hit;
    logic [1:0] run;
    logic [1:0][3:0] match;
    logic [1:0] clr_own;
    logic [1:0] clr;
    logic pwm_on;
    logic [2:0] dm;
    logic [7:0] pin_nxt;

    assign idx = 24'(PADDR[ADDR_W-1:2]);
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign ocr_wr = wr_acc && idx == IDX_OCR;

    // apb read decode; unmapped indices read zero and flag an error
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (idx)
            IDX_START: rd_val = {30'h0000_0000, start_r};
            IDX_MODE: rd_val = {24'h00_0000, mode_r};
            IDX_FUNC: rd_val = {24'h00_0000, func_r};
            IDX_OE: rd_val = {24'h00_0000, oe_r};
            IDX_OCR: rd_val = {24'h00_0000, ocr_r};
            IDX_TCR[0]: rd_val = {24'h00_0000, tcr_r[0]};
            IDX_TCR[1]: rd_val = {24'h00_0000, tcr_r[1]};
            IDX_CNT[0]: rd_val = {16'h0000, cnt_r[0]};
            IDX_CNT[1]: rd_val = {16'h0000, cnt_r[1]};
            IDX_GR[0][0]: rd_val = {16'h0000, gr_r[0][0]};
            IDX_GR[0][1]: rd_val = {16'h0000, gr_r[0][1]};
            IDX_GR[0][2]: rd_val = {16'h0000, gr_r[0][2]};
            IDX_GR[0][3]: rd_val = {16'h0000, gr_r[0][3]};
            IDX_GR[1][0]: rd_val = {16'h0000, gr_r[1][0]};
            IDX_GR[1][1]: rd_val = {16'h0000, gr_r[1][1]};
            IDX_GR[1][2]: rd_val = {16'h0000, gr_r[1][2]};
            IDX_GR[1][3]: rd_val = {16'h0000, gr_r[1][3]};
            default: hit = 1'b0;
        endcase
    end

    // read data is sampled in the setup cycle, so the access phase never waits
    always_ff @(posedge CLK) begin
        if (SRST) begin
            prdata_r <= 32'h0000_0000;
            hit_r <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            prdata_r <= rd_val;
            hit_r <= hit;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit_r;

    // configuration registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            start_r <= START_RST;
            mode_r <= MODE_RST;
            func_r <= FUNC_RST;
            oe_r <= OE_RST;
            ocr_r <= OCR_RST;
            tcr_r[0] <= TCR_RST;
            tcr_r[1] <= TCR_RST;
        end else if (wr_acc) begin
            if (idx == IDX_START) start_r <= PWDATA[1:0];
            if (idx == IDX_MODE) mode_r <= PWDATA[7:0];
            if (idx == IDX_FUNC) func_r <= PWDATA[7:0];
            if (idx == IDX_OE) oe_r <= PWDATA[7:0];
            if (ocr_wr) ocr_r <= PWDATA[7:0];
            for (int c = 0; c < 2; c++) begin
                if (idx == IDX_TCR[c]) tcr_r[c] <= PWDATA[7:0];
            end
        end
    end

    // only the system clock, rising edge, is a count source; other selections hold the counter
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            run[c] = start_r[c] && tcr_r[c][4:3] == EDGE_RISE && tcr_r[c][2:0] == PSC_SYS;
            for (int g = 0; g < 4; g++) begin
                match[c][g] = run[c] && cnt_r[c] == gr_r[c][g];
            end
            clr_own[c] = match[c][0] && tcr_r[c][7:5] == CLR_PERIOD;
        end
        // synchronous mode shares the clear; with the bit clear each counter is on its own
        clr[0] = clr_own[0] || (mode_r[MODE_SYNC] && clr_own[1]);
        clr[1] = clr_own[1] || (mode_r[MODE_SYNC] && clr_own[0]);
    end

    // a software write to a counter wins over counting and clearing
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_r[0] <= CNT_RST;
            cnt_r[1] <= CNT_RST;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_acc && idx == IDX_CNT[c]) begin
                    cnt_r[c] <= PWDATA[15:0];
                end else if (clr[c]) begin
                    cnt_r[c] <= CNT_RST;
                end else if (run[c]) begin
                    cnt_r[c] <= cnt_r[c] + 16'h0001;
                end
            end
        end
    end

    // general registers; c and d feed a and b on the channel's own compare-a match when buffered
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int c = 0; c < 2; c++) begin
                for (int g = 0; g < 4; g++) begin
                    gr_r[c][g] <= GR_RST;
                end
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                for (int g = 0; g < 4; g++) begin
                    if (wr_acc && idx == IDX_GR[c][g]) begin
                        gr_r[c][g] <= PWDATA[15:0];
                    end else if (g < 2 && match[c][0] && mode_r[MODE_BUF_LSB + 2 * c + g % 2]) begin
                        gr_r[c][g] <= gr_r[c][g % 2 + 2];
                    end
                end
            end
        end
    end

    // compare-toggle levels, preset from the initial level register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            lvl_r <= OCR_RST;
        end else if (ocr_wr) begin
            lvl_r <= PWDATA[7:0];
        end else begin
            for (int p = 0; p < 8; p++) begin
                if (match[p / 4][p % 4]) lvl_r[p] <= ~lvl_r[p];
            end
        end
    end

    assign pwm_on = func_r[1:0] == CMD_RSPWM;
    // all three duty compares run against the period counter
    assign dm[0] = run[0] && cnt_r[0] == gr_r[0][1];
    assign dm[1] = run[0] && cnt_r[0] == gr_r[1][0];
    assign dm[2] = run[0] && cnt_r[0] == gr_r[1][1];

    // duty equal to period gives a pin that never goes active: the clear wins
    always_ff @(posedge CLK) begin
        if (SRST || !pwm_on) begin
            act_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (clr[0]) act_r[i] <= 1'b0;
                else if (dm[i]) act_r[i] <= 1'b1;
            end
        end
    end

    // pins show the preset levels until the first period clear or duty compare match of the period counter
    always_ff @(posedge CLK) begin
        if (SRST) begin
            started_r <= 1'b0;
        end else if (pwm_on && (clr[0] || |dm)) begin
            started_r <= 1'b1;
        end else if (ocr_wr || !pwm_on) begin
            started_r <= 1'b0;
        end
    end

    always_comb begin
        pin_nxt = lvl_r;
        if (pwm_on && started_r) begin
            pin_nxt[PIN_B0] = act_r[0] ^ ~func_r[FUNC_LVL_SEL0];
            pin_nxt[PIN_D0] = ~(act_r[0] ^ ~func_r[FUNC_LVL_SEL0]);
            pin_nxt[PIN_A1] = act_r[1] ^ ~func_r[FUNC_LVL_SEL1];
            pin_nxt[PIN_C1] = ~(act_r[1] ^ ~func_r[FUNC_LVL_SEL1]);
            pin_nxt[PIN_B1] = act_r[2] ^ ~func_r[FUNC_LVL_SEL1];
            pin_nxt[PIN_D1] = ~(act_r[2] ^ ~func_r[FUNC_LVL_SEL1]);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) pin_r <= OCR_RST;
        else pin_r <= pin_nxt;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq0_r <= 1'b0;
            irq1_r <= 1'b0;
        end else begin
            irq0_r <= match[0][2];
            irq1_r <= match[1][2];
        end
    end

    assign TIMER_PIN_O = rspwm_pins_t'(pin_r);
    assign TIMER_PIN_OE = rspwm_pins_t'(~oe_r);
    assign SECOND_TOGGLE_O = lvl_r[PIN_C1];
    assign FIRST_CHANNEL_IRQ = irq0_r;
    assign SECOND_CHANNEL_IRQ = irq1_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_duty_one;
        pwm_on && dm[0] && !clr[0] && !ocr_wr;
    endsequence

    sequence s_hold_cfg;
        $stable(func_r) && !ocr_wr && !clr[0];
    endsequence

    property p_count_up;
        run[0] && !clr[0] && !(wr_acc && idx == IDX_CNT[0]) |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("period counter did not advance");

    property p_period_clear;
        match[0][0] && tcr_r[0][7:5] == CLR_PERIOD && !(wr_acc && idx == IDX_CNT[0]) |=> cnt_r[0] == 16'h0000;
    endproperty
    a_period_clear: assert property (p_period_clear) else $error("period counter not cleared");

    property p_sync_toggle;
        match[0][2] && !ocr_wr |-> ##2 TIMER_PIN_O.period_sync_pin != $past(TIMER_PIN_O.period_sync_pin);
    endproperty
    a_sync_toggle: assert property (p_sync_toggle) else $error("period sync pin did not toggle");

    property p_inverse;
        pwm_on && started_r |=> TIMER_PIN_O.pwm_one_inverse_pin != TIMER_PIN_O.pwm_one_pin;
    endproperty
    a_inverse: assert property (p_inverse) else $error("inverse pin equals pwm pin");

    property p_irq_first;
        FIRST_CHANNEL_IRQ |-> $past(run[0]) && $past(cnt_r[0]) == $past(gr_r[0][2]);
    endproperty
    a_irq_first: assert property (p_irq_first) else $error("first irq without compare match");

    property p_irq_second;
        SECOND_CHANNEL_IRQ |-> $past(run[1]) && $past(cnt_r[1]) == $past(gr_r[1][2]);
    endproperty
    a_irq_second: assert property (p_irq_second) else $error("second irq without compare match");

    property p_stopped;
        !start_r[1] && !(wr_acc && idx == IDX_CNT[1]) |=> $stable(cnt_r[1]);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved");

    property p_oe_write;
        wr_acc && idx == IDX_OE |=> TIMER_PIN_OE == rspwm_pins_t'(~$past(PWDATA[7:0]));
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("output enable not inverse of written bits");

    property p_duty_active;
        s_duty_one ##1 s_hold_cfg |=> TIMER_PIN_O.pwm_one_pin == $past(func_r[FUNC_LVL_SEL0]);
    endproperty
    a_duty_active: assert property (p_duty_active) else $error("pwm one not active after duty match");

endmodule // rspwm_timer
`default_nettype wire

// file: test/rspwm_stage_model.sv
// power stage model that flags overlapping drive of complementary legs
`timescale 1ns/1ps
`default_nettype none
module rspwm_stage_model import rspwm_pkg::*; (
    input wire logic clk,
    input wire rspwm_pins_t pin,
    input wire rspwm_pins_t oe,
    input wire logic armed,
    output int faults
);
    initial faults = 0;
    // equal levels on a driven leg pair would short the half bridge
    always @(posedge clk) begin
        if (armed && oe === 8'hff && (pin[PIN_B0] === pin[PIN_D0] || pin[PIN_A1] === pin[PIN_C1]
                || pin[PIN_B1] === pin[PIN_D1])) begin
            faults <= faults + 1;
        end
    end
endmodule // rspwm_stage_model
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the reset-synchronous pwm timer
`timescale 1ns/1ps
`default_nettype none
module tb_top import rspwm_pkg::*; ;
    localparam int P = 40;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, tog, irq0, irq1, err, armed, t0;
    logic [25:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'h0000_0032;
    rspwm_pins_t pin_o, pin_oe;
    logic [9:0] sv;
    int err_count = 0;
    int check_count = 0;
    int faults, n, d;
    logic [15:0] mdl [logic [23:0]];
    assign sv = {irq1, irq0, pin_o};

    rspwm_timer dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TIMER_PIN_O(pin_o), .TIMER_PIN_OE(pin_oe), .SECOND_TOGGLE_O(tog),
        .FIRST_CHANNEL_IRQ(irq0), .SECOND_CHANNEL_IRQ(irq1));
    rspwm_stage_model stage (.clk(clk), .pin(pin_o), .oe(pin_oe), .armed(armed), .faults(faults));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] msk(input logic [23:0] idx);
        if (idx == IDX_START) return 16'h0003;
        if (idx >= IDX_START || idx == IDX_TCR[0] || idx == IDX_TCR[1]) return 16'h00ff;
        return 16'hffff;
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cyc(input string nm, input int e, input int g);
        check_count++;
        if (g != e) begin
            err_count++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // one apb transfer; an idle edge first keeps psel from being driven twice in a step
    task automatic apb(input logic wr, input logic [23:0] idx, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_count++;
            close_out();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wreg(input logic [23:0] idx, input logic [15:0] v);
        apb(1'b1, idx, {16'h0000, v});
        mdl[idx] = v & msk(idx);
    endtask

    task automatic rall();
        foreach (mdl[i]) begin
            apb(1'b0, i, 32'h0000_0000);
            chk_val("register", {16'h0000, mdl[i]}, rd);
        end
    endtask

    // waits until sv[b] leaves lv, returns to it, then counts cycles spent at lv
    task automatic lvl_time(input int b, input logic lv, output int t);
        int k;
        k = 0;
        t = 0;
        while (sv[b] === lv && k < 300) begin
            @(posedge clk);
            k++;
        end
        while (sv[b] !== lv && k < 300) begin
            @(posedge clk);
            k++;
        end
        while (sv[b] === lv && k < 300) begin
            @(posedge clk);
            k++;
            t++;
        end
        if (k >= 300) begin
            err_count++;
            close_out();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        armed = 1'b0;
        mdl[IDX_START] = 16'(START_RST);
        mdl[IDX_MODE] = 16'(MODE_RST);
        mdl[IDX_FUNC] = 16'(FUNC_RST);
        mdl[IDX_OE] = 16'(OE_RST);
        mdl[IDX_OCR] = 16'(OCR_RST);
        for (int c = 0; c < 2; c++) begin
            mdl[IDX_TCR[c]] = 16'(TCR_RST);
            mdl[IDX_CNT[c]] = CNT_RST;
            for (int g = 0; g < 4; g++) mdl[IDX_GR[c][g]] = GR_RST;
        end
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk_val("pin enables", 32'h0000_0000, pin_oe);
        rall();
        apb(1'b1, 24'h00_0001, 32'hffff_ffff);
        chk_val("unmapped write error", 32'h0000_0001, err);
        apb(1'b0, 24'h00_0001, 32'h0000_0000);
        chk_val("unmapped read", 32'h0000_0000, rd);
        repeat (3) begin
            d = xs();
            wreg(IDX_OE, {8'h00, d[7:0]});
            @(posedge clk);
            chk_val("pin enables", {24'h00_0000, ~d[7:0]}, pin_oe);
        end
        wreg(IDX_OE, 16'h0000);
        wreg(IDX_FUNC, 16'h000d);
        wreg(IDX_TCR[0], 16'h0020);
        wreg(IDX_TCR[1], 16'h0000);
        wreg(IDX_GR[0][0], 16'(P));
        wreg(IDX_GR[0][2], 16'h000c);
        wreg(IDX_GR[1][0], 16'h000a);
        wreg(IDX_GR[1][1], 16'h001e);
        wreg(IDX_GR[1][2], 16'h0100);
        d = xs();
        wreg(IDX_OCR, {8'h00, d[7:0]});
        // pins are registered behind the level register: one more edge before they settle
        repeat (2) @(posedge clk);
        chk_val("initial levels", {24'h00_0000, d[7:0]}, pin_o);
        rall();
        wreg(IDX_START, 16'h0003);
        for (int k = 0; k < 4; k++) begin
            lvl_time(8, 1'b0, n);
            if (k > 0) chk_cyc("irq0 gap", P, n);
            d = 1 + int'(xs() % (P - 1));
            wreg(IDX_GR[0][1], 16'(d));
            lvl_time(PIN_B0, 1'b1, n);
            lvl_time(PIN_B0, 1'b1, n);
            chk_cyc("pwm one high", P - d, n);
            armed <= 1'b1;
        end
        lvl_time(PIN_A1, 1'b1, n);
        chk_cyc("pwm two high", P - 10, n);
        lvl_time(PIN_B1, 1'b1, n);
        chk_cyc("pwm three high", P - 30, n);
        lvl_time(2, 1'b1, n);
        chk_cyc("sync level", P + 1, n);
        armed <= 1'b0;
        wreg(IDX_FUNC, 16'h0001);
        lvl_time(PIN_B0, 1'b0, n);
        lvl_time(PIN_B0, 1'b0, n);
        chk_cyc("pwm one active low", P - d, n);
        // third compare is loaded first so every buffered copy brings the new period
        wreg(IDX_GR[0][2], 16'h0020);
        wreg(IDX_MODE, 16'h0010);
        lvl_time(8, 1'b0, n);
        lvl_time(8, 1'b0, n);
        chk_cyc("buffered period gap", 16'h0020, n);
        apb(1'b0, IDX_GR[0][0], 32'h0000_0000);
        chk_val("buffered period", 32'h0000_0020, rd);
        wreg(IDX_START, 16'h0002);
        wreg(IDX_CNT[0], 16'h1234);
        repeat (5) @(posedge clk);
        apb(1'b0, IDX_CNT[0], 32'h0000_0000);
        chk_val("stopped counter", 32'h0000_1234, rd);
        t0 = tog;
        wreg(IDX_CNT[1], 16'h00f8);
        lvl_time(9, 1'b1, n);
        chk_cyc("irq1 pulse", 1, n);
        chk_val("second toggle", {31'h0, ~t0}, {31'h0, tog});
        repeat (20) @(posedge clk);
        wreg(IDX_START, 16'h0000);
        apb(1'b0, IDX_CNT[1], 32'h0000_0000);
        chk_val("free run past compare", 32'h0000_0001, {31'h0, rd[15:0] > 16'h0100});
        chk_cyc("leg overlap", 0, faults);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
